// >>> hw/pch_defs.svh
// Offsets, field positions and fixed values of the configuration header bank.
`ifndef PCH_DEFS_SVH
`define PCH_DEFS_SVH
`define PCH_OFF_CMDSTAT 8'h04
`define PCH_OFF_MEMBAR 8'h10
`define PCH_OFF_IOBAR 8'h14
`define PCH_OFF_INTR 8'h3c
`define PCH_CMD_IO_EN 0
`define PCH_CMD_MEM_EN 1
`define PCH_CMD_MASTER 2
`define PCH_CMD_PERR_RESP 6
`define PCH_CMD_SERR_EN 8
`define PCH_ST_CAP66 5
`define PCH_ST_DPAR 8
`define PCH_ST_DEVSEL 9
`define PCH_ST_SIG_TABORT 11
`define PCH_ST_RCV_TABORT 12
`define PCH_ST_RCV_MABORT 13
`define PCH_ST_SIG_SERR 14
`define PCH_ST_PERR_DET 15
`define PCH_ST_LSB 16
`define PCH_DEVSEL_SLOW 2'h2
`define PCH_MEM_TYPE 4'h8
`define PCH_IO_TYPE 2'h1
`define PCH_INT_PIN 8'h01
`define PCH_INT_LINE_RST 8'h00
`define PCH_MEM_SIZE_LOG2 24
`define PCH_IO_SIZE_LOG2 8
`endif

// >>> hw/pch_pkg.sv
// Types shared by the configuration header bank modules.
`default_nettype none
package pch_pkg;
  // Bus command codes seen in the address phase.
  typedef enum logic [3:0] {
    pch_op_io_rd = 4'h2,
    pch_op_io_wr = 4'h3,
    pch_op_mem_rd = 4'h6,
    pch_op_mem_wr = 4'h7,
    pch_op_cfg_rd = 4'ha,
    pch_op_cfg_wr = 4'hb
  } pch_op_type;
  // Sticky error flags of the status word.
  typedef struct packed {
    logic perr_det;
    logic sig_serr;
    logic rcv_mabort;
    logic rcv_tabort;
    logic sig_tabort;
    logic dpar_err;
  } pch_flags_type;
endpackage
`default_nettype wire

// >>> hw/pch_acc_if.sv
// Decoded configuration access passed from the decoder to the register bank.
`timescale 1ns/1ps
`default_nettype none
interface pch_acc_if;
  logic rd;
  logic wr;
  logic [7:0] off;
  logic [3:0] be;
  logic [31:0] wdata;
  modport src (output rd, output wr, output off, output be, output wdata);
  modport dst (input rd, input wr, input off, input be, input wdata);
endinterface
`default_nettype wire

// >>> hw/pch_cfg_decode.sv
// Configuration access decoder: selects this function and forms the access.
`timescale 1ns/1ps
`default_nettype none
module pch_cfg_decode (
  // Raw configuration request
  input wire logic cfg_valid_i,
  input wire logic cfg_idsel_i,
  input wire logic [3:0] cfg_cmd_i,
  input wire logic [31:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_n_i,
  input wire logic [31:0] cfg_wdata_i,
  // Decoded access
  pch_acc_if.src acc
);
  import pch_pkg::*;
  logic sel;
  // The function is chosen only by its ID select with a doubleword-aligned address.
  assign sel = cfg_valid_i & cfg_idsel_i & (cfg_addr_i[1:0] == 2'h0);
  // Read and write are told apart by the command code.
  assign acc.rd = sel & (cfg_cmd_i == pch_op_cfg_rd);
  assign acc.wr = sel & (cfg_cmd_i == pch_op_cfg_wr);
  // Bits 7-2 pick the doubleword; byte enables arrive active low.
  assign acc.off = {cfg_addr_i[7:2], 2'h0};
  assign acc.be = ~cfg_be_n_i;
  assign acc.wdata = cfg_wdata_i;
endmodule
`default_nettype wire

// >>> hw/pch_addr_hit.sv
// Address hit comparator for the memory and I/O windows.
`timescale 1ns/1ps
`default_nettype none
`include "pch_defs.svh"
module pch_addr_hit #(
  parameter int MEM_SIZE_LOG2 = `PCH_MEM_SIZE_LOG2,
  parameter int IO_SIZE_LOG2 = `PCH_IO_SIZE_LOG2
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Address phase
  input wire logic txn_valid_i,
  input wire logic [3:0] txn_cmd_i,
  input wire logic [31:0] txn_addr_i,
  // Window setup
  input wire logic mem_en_i,
  input wire logic io_en_i,
  input wire logic [31-MEM_SIZE_LOG2:0] mem_base_i,
  input wire logic [31-IO_SIZE_LOG2:0] io_base_i,
  // Hit results
  output logic mem_hit_o,
  output logic io_hit_o
);
  import pch_pkg::*;
  typedef struct packed {
    logic mem_hit;
    logic io_hit;
  } pch_hit_type;
  pch_hit_type s_q, s_d;
  // Tells whether a command code is of the given read/write pair.
  function automatic logic op_pair(input logic [3:0] c, input logic [3:0] rd);
    return (c == rd) || (c == (rd | 4'h1));
  endfunction
  // A hit needs the space enabled, the right command and the upper address bits.
  always_comb begin
    s_d.mem_hit = txn_valid_i & mem_en_i & op_pair(txn_cmd_i, pch_op_mem_rd) &
      (txn_addr_i[31:MEM_SIZE_LOG2] == mem_base_i);
    s_d.io_hit = txn_valid_i & io_en_i & op_pair(txn_cmd_i, pch_op_io_rd) &
      (txn_addr_i[31:IO_SIZE_LOG2] == io_base_i);
  end
  // Hit results are registered.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign mem_hit_o = s_q.mem_hit;
  assign io_hit_o = s_q.io_hit;
endmodule
`default_nettype wire

// >>> hw/pch_cfg_regs.sv
// Configuration header register bank: command, status, windows and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "pch_defs.svh"
module pch_cfg_regs #(
  parameter int MEM_SIZE_LOG2 = `PCH_MEM_SIZE_LOG2,
  parameter int IO_SIZE_LOG2 = `PCH_IO_SIZE_LOG2,
  parameter bit CAP_66MHZ = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Configuration access
  input wire logic cfg_valid_i,
  input wire logic cfg_idsel_i,
  input wire logic [3:0] cfg_cmd_i,
  input wire logic [31:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_n_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // Address phase of memory and I/O transactions
  input wire logic txn_valid_i,
  input wire logic [3:0] txn_cmd_i,
  input wire logic [31:0] txn_addr_i,
  output logic mem_hit_o,
  output logic io_hit_o,
  // Error events from target and DMA master logic
  input wire logic dpar_err_i,
  input wire logic tabort_sig_i,
  input wire logic dma_tabort_i,
  input wire logic dma_mabort_i,
  input wire logic serr_req_i,
  input wire logic perr_req_i,
  // Error pins and controls
  output logic serr_o,
  output logic serr_oe_o,
  output logic perr_o,
  output logic perr_oe_o,
  output logic parity_check_en_o,
  output logic mem_space_en_o,
  output logic io_space_en_o
);
  import pch_pkg::*;

  // Widths of the writable base fields follow the window sizes.
  localparam int MW = 32 - MEM_SIZE_LOG2;
  localparam int IW = 32 - IO_SIZE_LOG2;

  typedef struct packed {
    logic io_en;
    logic mem_en;
    logic perr_resp;
    logic serr_en;
    pch_flags_type flags;
    logic [MW-1:0] mem_base;
    logic [IW-1:0] io_base;
    logic [7:0] int_line;
    logic [31:0] rdata;
    logic rvalid;
  } pch_state_type;

  pch_state_type s_q, s_d;
  pch_acc_if acc ();
  logic [15:0] cmd_w;
  logic [15:0] stat_w;
  logic [31:0] mem_w;
  logic [31:0] io_w;
  logic [31:0] int_w;
  logic [31:0] clr;
  logic [31:0] m;

  // Expands byte enables to a bit mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Replaces only the enabled bytes of a word.
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    return (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction

  // Next value of a sticky flag; a new event beats a clear in the same cycle.
  function automatic logic w1c(input logic old, input logic set, input logic clr_b);
    return set | (old & ~clr_b);
  endfunction

  // Selects this function and forms the decoded access.
  pch_cfg_decode u_decode (
    .cfg_valid_i(cfg_valid_i),
    .cfg_idsel_i(cfg_idsel_i),
    .cfg_cmd_i(cfg_cmd_i),
    .cfg_addr_i(cfg_addr_i),
    .cfg_be_n_i(cfg_be_n_i),
    .cfg_wdata_i(cfg_wdata_i),
    .acc(acc.src)
  );

  // Compares transaction addresses against the programmed windows.
  pch_addr_hit #(
    .MEM_SIZE_LOG2(MEM_SIZE_LOG2),
    .IO_SIZE_LOG2(IO_SIZE_LOG2)
  ) u_hit (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .txn_valid_i(txn_valid_i),
    .txn_cmd_i(txn_cmd_i),
    .txn_addr_i(txn_addr_i),
    .mem_en_i(s_q.mem_en),
    .io_en_i(s_q.io_en),
    .mem_base_i(s_q.mem_base),
    .io_base_i(s_q.io_base),
    .mem_hit_o(mem_hit_o),
    .io_hit_o(io_hit_o)
  );

  // Read views of every register, with fixed bits filled in.
  always_comb begin
    cmd_w = 16'h0000;
    cmd_w[`PCH_CMD_IO_EN] = s_q.io_en;
    cmd_w[`PCH_CMD_MEM_EN] = s_q.mem_en;
    cmd_w[`PCH_CMD_MASTER] = 1'b1;
    cmd_w[`PCH_CMD_PERR_RESP] = s_q.perr_resp;
    cmd_w[`PCH_CMD_SERR_EN] = s_q.serr_en; // Remaining bits stay zero.
    stat_w = 16'h0000; // Reserved bits read zero; CAP_66MHZ and the DEVSEL timing are filled in below.
    stat_w[`PCH_ST_CAP66] = CAP_66MHZ;
    stat_w[`PCH_ST_DPAR] = s_q.flags.dpar_err;
    stat_w[`PCH_ST_DEVSEL +: 2] = `PCH_DEVSEL_SLOW;
    stat_w[`PCH_ST_SIG_TABORT] = s_q.flags.sig_tabort;
    stat_w[`PCH_ST_RCV_TABORT] = s_q.flags.rcv_tabort;
    stat_w[`PCH_ST_RCV_MABORT] = s_q.flags.rcv_mabort;
    stat_w[`PCH_ST_SIG_SERR] = s_q.flags.sig_serr;
    stat_w[`PCH_ST_PERR_DET] = s_q.flags.perr_det;
    mem_w = {s_q.mem_base, {(MEM_SIZE_LOG2-4){1'b0}}, `PCH_MEM_TYPE};
    io_w = {s_q.io_base, {(IO_SIZE_LOG2-2){1'b0}}, `PCH_IO_TYPE};
    int_w = {16'h0000, s_q.int_line, `PCH_INT_PIN};
  end

  // Bits that a status write asks to clear; only ones in enabled lanes count.
  always_comb begin
    clr = 32'h0000_0000;
    if (acc.wr && (acc.off == `PCH_OFF_CMDSTAT)) begin
      clr = acc.wdata & lane_mask(acc.be);
    end
  end

  // Next state: configuration writes, flag updates and read capture.
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    m = 32'h0000_0000;
    if (acc.wr) begin
      case (acc.off)
        `PCH_OFF_CMDSTAT: begin
          // Only the command lanes carry stored bits.
          m = wr_merge({16'h0000, cmd_w}, acc.wdata, acc.be & 4'h3);
          s_d.io_en = m[`PCH_CMD_IO_EN];
          s_d.mem_en = m[`PCH_CMD_MEM_EN];
          s_d.perr_resp = m[`PCH_CMD_PERR_RESP];
          s_d.serr_en = m[`PCH_CMD_SERR_EN];
        end
        `PCH_OFF_MEMBAR: begin
          m = wr_merge(mem_w, acc.wdata, acc.be);
          s_d.mem_base = m[31:MEM_SIZE_LOG2];
        end
        `PCH_OFF_IOBAR: begin
          m = wr_merge(io_w, acc.wdata, acc.be);
          s_d.io_base = m[31:IO_SIZE_LOG2];
        end
        `PCH_OFF_INTR: begin
          m = wr_merge(int_w, acc.wdata, acc.be);
          s_d.int_line = m[15:8]; // Stored only, never used inside.
        end
        default: begin
          m = 32'h0000_0000;
        end
      endcase
    end
    // Sticky flags; parity detection is ignored while parity response is off.
    s_d.flags.dpar_err = w1c(s_q.flags.dpar_err, dpar_err_i & s_q.perr_resp,
      clr[`PCH_ST_LSB+`PCH_ST_DPAR]);
    s_d.flags.sig_tabort = w1c(s_q.flags.sig_tabort, tabort_sig_i,
      clr[`PCH_ST_LSB+`PCH_ST_SIG_TABORT]);
    s_d.flags.rcv_tabort = w1c(s_q.flags.rcv_tabort, dma_tabort_i,
      clr[`PCH_ST_LSB+`PCH_ST_RCV_TABORT]);
    s_d.flags.rcv_mabort = w1c(s_q.flags.rcv_mabort, dma_mabort_i,
      clr[`PCH_ST_LSB+`PCH_ST_RCV_MABORT]);
    s_d.flags.sig_serr = w1c(s_q.flags.sig_serr, serr_oe_o,
      clr[`PCH_ST_LSB+`PCH_ST_SIG_SERR]);
    s_d.flags.perr_det = w1c(s_q.flags.perr_det, perr_oe_o,
      clr[`PCH_ST_LSB+`PCH_ST_PERR_DET]);
    // Reads return the register one cycle after the access; unmapped reads give zero.
    if (acc.rd) begin
      s_d.rvalid = 1'b1;
      case (acc.off)
        `PCH_OFF_CMDSTAT: s_d.rdata = {stat_w, cmd_w};
        `PCH_OFF_MEMBAR: s_d.rdata = mem_w;
        `PCH_OFF_IOBAR: s_d.rdata = io_w;
        `PCH_OFF_INTR: s_d.rdata = int_w;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; every control bit and flag clears at reset.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.int_line <= `PCH_INT_LINE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Error pins drive low only when their enables allow it.
  assign serr_oe_o = s_q.serr_en & serr_req_i;
  assign perr_oe_o = s_q.perr_resp & perr_req_i;
  assign serr_o = 1'b0;
  assign perr_o = 1'b0;
  assign parity_check_en_o = s_q.perr_resp;
  assign mem_space_en_o = s_q.mem_en;
  assign io_space_en_o = s_q.io_en;
  assign cfg_rdata_o = s_q.rdata;
  assign cfg_rvalid_o = s_q.rvalid;

  // Checks on the bank's behaviour.
  property p_io_gate;
    @(posedge mclk_i) disable iff (rst_i)
    io_hit_o |-> $past(s_q.io_en) && $past(txn_addr_i[31:IO_SIZE_LOG2]) == $past(s_q.io_base);
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("I/O hit without enable or match");

  property p_mem_gate;
    @(posedge mclk_i) disable iff (rst_i)
    mem_hit_o |-> $past(s_q.mem_en) && $past(txn_addr_i[31:MEM_SIZE_LOG2]) == $past(s_q.mem_base);
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("Memory hit without enable or match");

  property p_cmd_fixed;
    @(posedge mclk_i) disable iff (rst_i)
    acc.rd && acc.off == `PCH_OFF_CMDSTAT |=> cfg_rvalid_o && cfg_rdata_o[2] &&
      (cfg_rdata_o[15:0] & 16'hfeb8) == 16'h0000;
  endproperty
  a_cmd_fixed: assert property (p_cmd_fixed) else $error("Fixed command bits wrong");

  property p_stat_fixed;
    @(posedge mclk_i) disable iff (rst_i)
    acc.rd && acc.off == `PCH_OFF_CMDSTAT |=> cfg_rdata_o[20:16] == 5'h00 &&
      cfg_rdata_o[23:22] == 2'h0 && cfg_rdata_o[21] == CAP_66MHZ && cfg_rdata_o[26:25] == 2'h2;
  endproperty
  a_stat_fixed: assert property (p_stat_fixed) else $error("Fixed status bits wrong");

  property p_bar_low;
    @(posedge mclk_i) disable iff (rst_i)
    acc.rd && acc.off == `PCH_OFF_MEMBAR |=> cfg_rdata_o[MEM_SIZE_LOG2-1:0] == 4'h8;
  endproperty
  a_bar_low: assert property (p_bar_low) else $error("Memory window low bits wrong");

  property p_io_low;
    @(posedge mclk_i) disable iff (rst_i)
    acc.rd && acc.off == `PCH_OFF_IOBAR |=> cfg_rdata_o[IO_SIZE_LOG2-1:0] == 2'h1;
  endproperty
  a_io_low: assert property (p_io_low) else $error("I/O window low bits wrong");

  property p_int_pin;
    @(posedge mclk_i) disable iff (rst_i)
    acc.rd && acc.off == `PCH_OFF_INTR |=> cfg_rdata_o[7:0] == 8'h01;
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("Interrupt pin field wrong");

  property p_int_line;
    @(posedge mclk_i) disable iff (rst_i)
    acc.wr && acc.off == `PCH_OFF_INTR && acc.be[1] |=> s_q.int_line == $past(acc.wdata[15:8]);
  endproperty
  a_int_line: assert property (p_int_line) else $error("Interrupt line not stored");

  property p_parity_off;
    @(posedge mclk_i) disable iff (rst_i)
    !s_q.perr_resp && !s_q.flags.dpar_err |=> !s_q.flags.dpar_err;
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("Parity flag set while ignored");

  property p_serr_off;
    @(posedge mclk_i) disable iff (rst_i)
    !s_q.serr_en |-> !serr_oe_o;
  endproperty
  a_serr_off: assert property (p_serr_off) else $error("SERR driven while disabled");

  property p_sticky;
    @(posedge mclk_i) disable iff (rst_i)
    s_q.flags.rcv_mabort && !clr[`PCH_ST_LSB+`PCH_ST_RCV_MABORT] |=> s_q.flags.rcv_mabort;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Master abort flag lost");

  property p_set_wins;
    @(posedge mclk_i) disable iff (rst_i)
    tabort_sig_i && clr[`PCH_ST_LSB+`PCH_ST_SIG_TABORT] |=> s_q.flags.sig_tabort;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("Abort event lost to a clear");

  property p_w1c;
    @(posedge mclk_i) disable iff (rst_i)
    !serr_oe_o && clr[`PCH_ST_LSB+`PCH_ST_SIG_SERR] |=> !s_q.flags.sig_serr;
  endproperty
  a_w1c: assert property (p_w1c) else $error("Status flag not cleared by one");

  property p_perr_flag;
    @(posedge mclk_i) disable iff (rst_i)
    perr_oe_o |=> s_q.flags.perr_det ##1 (s_q.flags.perr_det || $past(clr[31]));
  endproperty
  a_perr_flag: assert property (p_perr_flag) else $error("PERR flag not set");

  // Main scenarios.
  c_cfg_read: cover property (@(posedge mclk_i) disable iff (rst_i) acc.rd ##1 cfg_rvalid_o);
  c_mem_hit: cover property (@(posedge mclk_i) disable iff (rst_i) acc.wr ##[1:20] mem_hit_o);
  c_io_hit: cover property (@(posedge mclk_i) disable iff (rst_i) acc.wr ##[1:20] io_hit_o);
  c_flag_clr: cover property (@(posedge mclk_i) disable iff (rst_i)
    s_q.flags.dpar_err ##1 !s_q.flags.dpar_err);
endmodule
`default_nettype wire

// >>> tb/pch_host_model.sv
// Host model that issues configuration accesses and address phases.
`timescale 1ns/1ps
`default_nettype none
module pch_host_model (
  // Clock
  input wire logic mclk_i,
  // Configuration request and answer
  output logic cfg_valid_o,
  output logic cfg_idsel_o,
  output logic [3:0] cfg_cmd_o,
  output logic [31:0] cfg_addr_o,
  output logic [3:0] cfg_be_n_o,
  output logic [31:0] cfg_wdata_o,
  input wire logic [31:0] cfg_rdata_i,
  input wire logic cfg_rvalid_i,
  // Address phase and hit answer
  output logic txn_valid_o,
  output logic [3:0] txn_cmd_o,
  output logic [31:0] txn_addr_o,
  input wire logic mem_hit_i,
  input wire logic io_hit_i
);
  // The bus is idle at time zero.
  initial begin
    cfg_valid_o = 1'b0;
    cfg_idsel_o = 1'b0;
    cfg_cmd_o = 4'h0;
    cfg_addr_o = 32'h0;
    cfg_be_n_o = 4'hf;
    cfg_wdata_o = 32'h0;
    txn_valid_o = 1'b0;
    txn_cmd_o = 4'h0;
    txn_addr_o = 32'h0;
  end

  // One access held for one edge; released lines show inverted values, not stale ones.
  task automatic cfg(input logic [3:0] cmd, input logic idsel, input logic [31:0] addr,
                     input logic [3:0] be_n, input logic [31:0] wd,
                     output logic [31:0] rd, output logic got);
    @(posedge mclk_i);
    #1;
    cfg_valid_o = 1'b1;
    cfg_idsel_o = idsel;
    cfg_cmd_o = cmd;
    cfg_addr_o = addr;
    cfg_be_n_o = be_n;
    cfg_wdata_o = wd;
    @(posedge mclk_i);
    #1;
    got = cfg_rvalid_i;
    rd = cfg_rdata_i;
    cfg_valid_o = 1'b0;
    cfg_idsel_o = 1'b0;
    cfg_cmd_o = ~cmd;
    cfg_addr_o = ~addr;
    cfg_be_n_o = ~be_n;
    cfg_wdata_o = ~wd;
  endtask

  // One address phase; the hit flags are sampled in the following cycle.
  task automatic txn(input logic [3:0] cmd, input logic [31:0] addr,
                     output logic mh, output logic ih);
    @(posedge mclk_i);
    #1;
    txn_valid_o = 1'b1;
    txn_cmd_o = cmd;
    txn_addr_o = addr;
    @(posedge mclk_i);
    #1;
    mh = mem_hit_i;
    ih = io_hit_i;
    txn_valid_o = 1'b0;
    txn_cmd_o = ~cmd;
    txn_addr_o = ~addr;
  endtask
endmodule
`default_nettype wire

// >>> tb/pch_cfg_regs_tb.sv
// Self-checking testbench of the configuration header register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module pch_cfg_regs_tb;
  localparam logic [15:0] ST0 = 16'h0420;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] ev = 6'h00;
  logic cfg_valid, cfg_idsel, cfg_rvalid, txn_valid, mem_hit, io_hit;
  logic [3:0] cfg_cmd, cfg_be_n, txn_cmd;
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, txn_addr;
  logic serr, serr_oe, perr, perr_oe, par_en, mem_en, io_en;
  int error_cnt = 0;
  int check_count = 0;
  int st_bit [6] = '{8, 11, 12, 13, 14, 15};

  // Free-running clock, 4 ns period.
  always #2 mclk_i = ~mclk_i;

  pch_cfg_regs #(.MEM_SIZE_LOG2(24), .IO_SIZE_LOG2(8), .CAP_66MHZ(1'b1)) pch_cfg_regs_inst (
    .mclk_i(mclk_i), .rst_i(rst_i),
    .cfg_valid_i(cfg_valid), .cfg_idsel_i(cfg_idsel), .cfg_cmd_i(cfg_cmd),
    .cfg_addr_i(cfg_addr), .cfg_be_n_i(cfg_be_n), .cfg_wdata_i(cfg_wdata),
    .cfg_rdata_o(cfg_rdata), .cfg_rvalid_o(cfg_rvalid),
    .txn_valid_i(txn_valid), .txn_cmd_i(txn_cmd), .txn_addr_i(txn_addr),
    .mem_hit_o(mem_hit), .io_hit_o(io_hit),
    .dpar_err_i(ev[0]), .tabort_sig_i(ev[1]), .dma_tabort_i(ev[2]), .dma_mabort_i(ev[3]),
    .serr_req_i(ev[4]), .perr_req_i(ev[5]),
    .serr_o(serr), .serr_oe_o(serr_oe), .perr_o(perr), .perr_oe_o(perr_oe),
    .parity_check_en_o(par_en), .mem_space_en_o(mem_en), .io_space_en_o(io_en)
  );

  pch_host_model pch_host_model_inst (
    .mclk_i(mclk_i),
    .cfg_valid_o(cfg_valid), .cfg_idsel_o(cfg_idsel), .cfg_cmd_o(cfg_cmd),
    .cfg_addr_o(cfg_addr), .cfg_be_n_o(cfg_be_n), .cfg_wdata_o(cfg_wdata),
    .cfg_rdata_i(cfg_rdata), .cfg_rvalid_i(cfg_rvalid),
    .txn_valid_o(txn_valid), .txn_cmd_o(txn_cmd), .txn_addr_o(txn_addr),
    .mem_hit_i(mem_hit), .io_hit_i(io_hit)
  );

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Configuration read that must answer with the expected dword.
  task automatic rd_chk(input logic [7:0] off, input logic [31:0] exp);
    logic [31:0] d;
    logic g;
    pch_host_model_inst.cfg(4'ha, 1'b1, {24'h0, off}, 4'h0, 32'h0, d, g);
    `CHK(g, 1'b1)
    `CHK(d, exp)
  endtask

  // Configuration write, which never answers with read data.
  task automatic wr(input logic [7:0] off, input logic [3:0] be_n, input logic [31:0] wd);
    logic [31:0] d;
    logic g;
    pch_host_model_inst.cfg(4'hb, 1'b1, {24'h0, off}, be_n, wd, d, g);
    `CHK(g, 1'b0)
  endtask

  // Access that must be ignored by this function.
  task automatic refused(input logic [3:0] cmd, input logic idsel, input logic [31:0] addr);
    logic [31:0] d;
    logic g;
    pch_host_model_inst.cfg(cmd, idsel, addr, 4'h0, 32'h0, d, g);
    `CHK(g, 1'b0)
  endtask

  // Address phase with expected memory and I/O hit flags.
  task automatic txn_chk(input logic [3:0] cmd, input logic [31:0] addr,
                         input logic em, input logic ei);
    logic m;
    logic i;
    pch_host_model_inst.txn(cmd, addr, m, i);
    `CHK({m, i}, {em, ei})
  endtask

  // One-cycle event pulse; the combinational pin enables are sampled meanwhile.
  task automatic pulse(input int i, output logic os, output logic op);
    @(posedge mclk_i);
    #1;
    ev[i] = 1'b1;
    #1;
    os = serr_oe;
    op = perr_oe;
    @(posedge mclk_i);
    #1;
    ev[i] = 1'b0;
  endtask

  // Register contents and enables right after a reset.
  task automatic defaults();
    rd_chk(8'h04, {ST0, 16'h0004});
    rd_chk(8'h10, 32'h0000_0008);
    rd_chk(8'h14, 32'h0000_0001);
    rd_chk(8'h3c, 32'h0000_0001);
    `CHK({mem_en, io_en, par_en, serr_oe, serr, perr}, 6'h00)
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    final_report();
  end

  // Main test sequence.
  initial begin
    logic [15:0] fl;
    logic [15:0] cw;
    logic os;
    logic op;
    repeat (12) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    defaults();
    // All ones into command and status: only writable command bits stick.
    wr(8'h04, 4'h0, 32'hffff_ffff);
    rd_chk(8'h04, {ST0, 16'h0147});
    `CHK({mem_en, io_en, par_en}, 3'b111)
    // Byte lanes of the windows and the interrupt register.
    wr(8'h10, 4'h7, 32'hffff_ffff);
    wr(8'h10, 4'h8, 32'h0);
    rd_chk(8'h10, 32'hff00_0008);
    wr(8'h14, 4'h0, 32'h1234_56ff);
    rd_chk(8'h14, 32'h1234_5601);
    wr(8'h3c, 4'h0, 32'hffff_a5fe);
    rd_chk(8'h3c, 32'h0000_a501);
    // Window hits with both spaces enabled.
    txn_chk(4'h6, 32'hff12_3456, 1'b1, 1'b0);
    txn_chk(4'h7, 32'hfeff_ffff, 1'b0, 1'b0);
    txn_chk(4'h2, 32'h1234_56ff, 1'b0, 1'b1);
    txn_chk(4'h3, 32'h1234_5700, 1'b0, 1'b0);
    txn_chk(4'ha, 32'hff00_0000, 1'b0, 1'b0);
    // Spaces disabled, parity response and system error enable kept.
    wr(8'h04, 4'hc, 32'h0000_0140);
    txn_chk(4'h7, 32'hff00_0000, 1'b0, 1'b0);
    txn_chk(4'h3, 32'h1234_5600, 1'b0, 1'b0);
    // Accesses that must not select this function.
    refused(4'ha, 1'b0, 32'h0000_003c);
    refused(4'ha, 1'b1, 32'h0000_003e);
    refused(4'h6, 1'b1, 32'h0000_003c);
    refused(4'hb, 1'b0, 32'h0000_003c);
    refused(4'hb, 1'b1, 32'h0000_003d);
    rd_chk(8'h3c, 32'h0000_a501);
    rd_chk(8'h40, 32'h0);
    // Each event with enables set, then with parity and system error enables clear.
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        wr(8'h04, 4'hc, 32'h0);
      end
      cw = (p == 0) ? 16'h0144 : 16'h0004;
      for (int i = 0; i < 6; i++) begin
        pulse(i, os, op);
        `CHK(os, p == 0 && i == 4)
        `CHK(op, p == 0 && i == 5)
        fl = (p == 0 || (i > 0 && i < 4)) ? 16'h1 << st_bit[i] : 16'h0;
        rd_chk(8'h04, {ST0 | fl, cw});
        wr(8'h04, 4'h7, 32'h0);
        rd_chk(8'h04, {ST0 | fl, cw});
        wr(8'h04, 4'h7, 32'hffff_ffff);
        rd_chk(8'h04, {ST0, cw});
      end
    end
    // A target abort in the same cycle as a write-one clear keeps its flag.
    fork
      pulse(1, os, op);
      wr(8'h04, 4'h7, 32'hffff_ffff);
    join
    rd_chk(8'h04, {ST0 | 16'h0800, 16'h0004});
    wr(8'h04, 4'h7, 32'hffff_ffff);
    rd_chk(8'h04, {ST0, 16'h0004});
    // Second reset in mid-run restores every default.
    @(posedge mclk_i);
    #1;
    rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    defaults();
    final_report();
  end
endmodule
`default_nettype wire
